// *** rtl/xio_port.sv ***
// extra i/o port: digital lines by byte group and four staged analog levels
//
// Design decision made here: the Avalon-MM register port.
`timescale 1ns/1ps
`default_nettype none
module xio_port
    import xio_pkg::*;
#(
    parameter int NUM_GROUPS = 3
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // avalon-mm slave
    input wire logic [xio_pkg::ADDR_W-1:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [3:0] byteenable,
    input wire logic [xio_pkg::DATA_W-1:0] writedata,
    output logic [xio_pkg::DATA_W-1:0] readdata,
    output logic waitrequest,
    output logic [1:0] response,
    // digital lines
    input wire logic [NUM_GROUPS*xio_pkg::GROUP_W-1:0] lineIn,
    output logic [NUM_GROUPS*xio_pkg::GROUP_W-1:0] lineOut,
    output logic [NUM_GROUPS*xio_pkg::GROUP_W-1:0] lineOe,
    // dac codes, offset binary
    output logic [xio_pkg::DAC_W-1:0] dacCode0,
    output logic [xio_pkg::DAC_W-1:0] dacCode1,
    output logic [xio_pkg::DAC_W-1:0] dacCode2,
    output logic [xio_pkg::DAC_W-1:0] dacCode3,
    output logic dacLoad
);
    import xio_pkg::*;
    localparam int LINES = NUM_GROUPS * GROUP_W;

    typedef enum logic [1:0] {
        XIO_IDLE = 2'b00,
        XIO_READ = 2'b01,
        XIO_DONE = 2'b10,
        XIO_DAC = 2'b11
    } xio_state_e;

    // millivolts to offset-binary dac code, clamped to the legal range
    function automatic logic [DAC_W-1:0] mvToCode(input logic [31:0] mv);
        logic signed [31:0] s;
        logic signed [31:0] steps;
        s = $signed(mv);
        if (s > LEVEL_MAX_MV) begin
            s = LEVEL_MAX_MV;
        end else if (s < -LEVEL_MAX_MV) begin
            s = -LEVEL_MAX_MV;
        end
        steps = s / LEVEL_STEP_MV;
        if (steps > 2047) begin
            mvToCode = DAC_TOP;
        end else begin
            mvToCode = DAC_MID + steps[DAC_W-1:0];
        end
    endfunction : mvToCode

    // pins are asynchronous, two flops before any use
    logic [LINES-1:0] pinMeta;
    logic [LINES-1:0] pinSync;
    always_ff @(posedge core_clk) begin
        if (rst) begin
            pinMeta <= '0;
            pinSync <= '0;
        end else begin
            pinMeta <= lineIn;
            pinSync <= pinMeta;
        end
    end

    xio_state_e state, next_state;
    logic [2:0] dir, next_dir;
    logic [LINES-1:0] next_lineOut, next_lineOe;
    logic [DATA_W-1:0] next_readdata;
    logic next_waitrequest;
    logic [1:0] next_response;
    logic [1:0] dacIdx, next_dacIdx;
    logic [DAC_W-1:0] stage [NUM_LEVELS];
    logic [DAC_W-1:0] next_stage [NUM_LEVELS];
    logic [DAC_W-1:0] next_dacCode0, next_dacCode1;
    logic [DAC_W-1:0] next_dacCode2, next_dacCode3;
    logic next_dacLoad;
    logic memWr;
    logic [1:0] memWrAddr, memRdAddr;
    logic [DATA_W-1:0] memRdData;
    logic [15:0] idx;
    logic isLevel;
    logic dacTail, next_dacTail;

    assign idx = address[ADDR_W-1:2];
    assign isLevel = (idx >= IDX_LEVEL_ZERO) && (idx <= IDX_LEVEL_THREE);
    assign memWrAddr = idx[1:0];
    assign memRdAddr = (state == XIO_DAC) ? dacIdx : idx[1:0];

    xio_level_mem #(.DEPTH(NUM_LEVELS), .WIDTH(DATA_W)) u_levels (
        .core_clk(core_clk),
        .rst(rst),
        .wrEn(memWr),
        .wrAddr(memWrAddr),
        .wrData(writedata),
        .rdAddr(memRdAddr),
        .rdData(memRdData)
    );

    always_comb begin
        next_state = state;
        next_dir = dir;
        next_lineOut = lineOut;
        next_readdata = readdata;
        next_waitrequest = 1'b1;
        next_response = response;
        next_dacIdx = dacIdx;
        next_stage = stage;
        next_dacCode0 = dacCode0;
        next_dacCode1 = dacCode1;
        next_dacCode2 = dacCode2;
        next_dacCode3 = dacCode3;
        next_dacLoad = 1'b0;
        memWr = 1'b0;
        case (state)
            XIO_IDLE: begin
                if (write) begin
                    next_response = 2'h0;
                    next_state = XIO_DONE;
                    next_waitrequest = 1'b0;
                    if (idx == IDX_PIN_DATA) begin
                        for (int g = 0; g < NUM_GROUPS; g++) begin
                            // input bytes and the top byte are dropped
                            if (dir[g] && byteenable[g]) begin
                                next_lineOut[g*GROUP_W +: GROUP_W] =
                                    writedata[g*GROUP_W +: GROUP_W];
                            end
                        end
                    end else if (isLevel) begin
                        memWr = 1'b1;
                    end else if (idx == IDX_DIRECTION) begin
                        if (byteenable[0]) begin
                            next_dir = writedata[2:0];
                        end
                    end else if (idx == IDX_UPDATE) begin
                        if (writedata == UPDATE_CMD) begin
                            next_state = XIO_DAC;
                            next_dacIdx = 2'h0;
                            next_waitrequest = 1'b1;
                        end
                    end else begin
                        next_response = 2'h3;
                    end
                end else if (read) begin
                    next_state = XIO_READ;
                end
            end
            XIO_READ: begin
                next_response = 2'h0;
                if (idx == IDX_PIN_DATA) begin
                    next_readdata = {{(DATA_W-LINES){1'b0}}, pinSync};
                end else if (isLevel) begin
                    next_readdata = memRdData;
                end else if (idx == IDX_DIRECTION) begin
                    next_readdata = {29'h0, dir};
                end else if (idx == IDX_UPDATE) begin
                    next_readdata = UNMAPPED_READ;
                end else begin
                    next_readdata = UNMAPPED_READ;
                    next_response = 2'h3;
                end
                next_waitrequest = 1'b0;
                next_state = XIO_DONE;
            end
            XIO_DAC: begin
                // one level per cycle, then a tail cycle loads every dac
                if (dacTail) begin
                    next_stage[NUM_LEVELS-1] = mvToCode(memRdData);
                    next_dacCode0 = next_stage[0];
                    next_dacCode1 = next_stage[1];
                    next_dacCode2 = next_stage[2];
                    next_dacCode3 = next_stage[3];
                    next_dacLoad = 1'b1;
                    next_waitrequest = 1'b0;
                    next_state = XIO_DONE;
                end else begin
                    next_dacIdx = dacIdx + 2'h1;
                    if (dacIdx != 2'h0) begin
                        // memory read data lags its address by one cycle
                        next_stage[dacIdx - 2'h1] =
                            mvToCode(memRdData);
                    end
                end
            end
            XIO_DONE: begin
                next_state = XIO_IDLE;
            end
            default: begin
                next_state = XIO_IDLE;
            end
        endcase
        next_lineOe = '0;
        for (int g = 0; g < NUM_GROUPS; g++) begin
            next_lineOe[g*GROUP_W +: GROUP_W] = {GROUP_W{next_dir[g]}};
        end
    end

    // final level read needs one extra cycle after the walk
    always_comb begin
        next_dacTail = (state == XIO_DAC) && (dacIdx == 2'h3);
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            state <= XIO_IDLE;
            dir <= DIR_RESET;
            lineOut <= '0;
            lineOe <= '0;
            readdata <= '0;
            waitrequest <= 1'b1;
            response <= 2'h0;
            dacIdx <= 2'h0;
            dacTail <= 1'b0;
            for (int i = 0; i < NUM_LEVELS; i++) begin
                stage[i] <= DAC_MID;
            end
            dacCode0 <= DAC_MID;
            dacCode1 <= DAC_MID;
            dacCode2 <= DAC_MID;
            dacCode3 <= DAC_MID;
            dacLoad <= 1'b0;
        end else begin
            state <= next_state;
            dir <= next_dir;
            lineOut <= next_lineOut;
            lineOe <= next_lineOe;
            readdata <= next_readdata;
            waitrequest <= next_waitrequest;
            response <= next_response;
            dacIdx <= next_dacIdx;
            dacTail <= next_dacTail;
            stage <= next_stage;
            // all four codes move on the same edge as the load pulse
            dacLoad <= next_dacLoad;
            dacCode0 <= next_dacCode0;
            dacCode1 <= next_dacCode1;
            dacCode2 <= next_dacCode2;
            dacCode3 <= next_dacCode3;
        end
    end

    // assertions
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    a_input_not_driven: assert property (
        !dir[0] |-> lineOe[GROUP_W-1:0] == '0)
        else $error("input group driven");
    a_input_byte_kept: assert property (
        !dir[0] |=> $stable(lineOut[GROUP_W-1:0]))
        else $error("input byte written");
    a_reset_all_input: assert property (
        $fell(rst) |-> lineOe == '0 && dir == DIR_RESET)
        else $error("lines driven after reset");
    a_dac_stable_idle: assert property (
        !dacLoad |-> $stable(dacCode0) && $stable(dacCode3))
        else $error("dac changed without load");
    a_dac_load_bound: assert property (
        (state == XIO_IDLE && write && idx == IDX_UPDATE &&
         writedata == UPDATE_CMD) |-> ##[1:8] dacLoad)
        else $error("update did not load dacs");
    a_bad_update_idle: assert property (
        (state == XIO_IDLE && write && idx == IDX_UPDATE &&
         writedata != UPDATE_CMD) |-> ##1 !dacLoad ##1 !dacLoad)
        else $error("update fired on wrong value");
    a_pin_readback: assert property (
        (state == XIO_READ && idx == IDX_PIN_DATA) |=>
        readdata[LINES-1:0] == $past(pinSync) &&
        readdata[DATA_W-1:LINES] == '0 && !waitrequest)
        else $error("pin data read wrong");
    a_lines_on_access: assert property (
        !$past(write) |-> $stable(lineOut))
        else $error("lines changed without write");
    a_top_byte_zero: assert property (
        (state == XIO_READ && idx == IDX_PIN_DATA) |=>
        readdata[31:24] == 8'h0)
        else $error("top byte not zero");
    a_dir_map: assert property (
        lineOe[GROUP_W] == dir[GROUP1_AS_OUTPUT])
        else $error("direction map wrong");
    c_pin_write: cover property (@(posedge core_clk) disable iff (rst)
        write && idx == IDX_PIN_DATA && !waitrequest);
    c_dac_load: cover property (@(posedge core_clk) disable iff (rst) dacLoad);
    c_level_read: cover property (@(posedge core_clk) disable iff (rst)
        state == XIO_READ && isLevel);
endmodule : xio_port
`default_nettype wire

// *** rtl/xio_pkg.sv ***
// package: register map, field layout and constants for the extra i/o port
package xio_pkg;
    // printed register indices; byte address is four times the index
    localparam logic [15:0] IDX_PIN_DATA = 16'hb806;
    localparam logic [15:0] IDX_LEVEL_ZERO = 16'hb810;
    localparam logic [15:0] IDX_LEVEL_ONE = 16'hb811;
    localparam logic [15:0] IDX_LEVEL_TWO = 16'hb812;
    localparam logic [15:0] IDX_LEVEL_THREE = 16'hb813;
    localparam logic [15:0] IDX_UPDATE = 16'hb81a;
    localparam logic [15:0] IDX_DIRECTION = 16'hb820;
    localparam int ADDR_W = 18;
    localparam int DATA_W = 32;
    localparam int NUM_LEVELS = 4;
    localparam int GROUP_W = 8;
    localparam int MAX_GROUPS = 3;
    localparam int DAC_W = 12;
    // direction bits
    localparam int GROUP0_AS_OUTPUT = 0;
    localparam int GROUP1_AS_OUTPUT = 1;
    localparam int GROUP2_AS_OUTPUT = 2;
    localparam logic [2:0] DIR_RESET = 3'h0;
    localparam logic [31:0] LEVEL_RESET = 32'h0;
    localparam logic [31:0] UPDATE_CMD = 32'h1;
    // level range in millivolts and step size
    localparam int LEVEL_MAX_MV = 10000;
    localparam int LEVEL_STEP_MV = 5;
    localparam logic [11:0] DAC_MID = 12'h800;
    localparam logic [11:0] DAC_TOP = 12'hfff;
    localparam logic [31:0] UNMAPPED_READ = 32'h0;

    function automatic logic [ADDR_W-1:0] byteAddr(input logic [15:0] idx);
        byteAddr = {idx, 2'h0};
    endfunction : byteAddr
endpackage : xio_pkg

// *** rtl/xio_level_mem.sv ***
// small register memory holding the programmed analog levels
`timescale 1ns/1ps
`default_nettype none
module xio_level_mem #(
    parameter int DEPTH = 4,
    parameter int WIDTH = 32
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // write port
    input wire logic wrEn,
    input wire logic [$clog2(DEPTH)-1:0] wrAddr,
    input wire logic [WIDTH-1:0] wrData,
    // registered read port
    input wire logic [$clog2(DEPTH)-1:0] rdAddr,
    output logic [WIDTH-1:0] rdData
);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [WIDTH-1:0] next_mem [DEPTH];
    logic [WIDTH-1:0] next_rdData;

    always_comb begin
        next_mem = mem;
        if (wrEn) begin
            next_mem[wrAddr] = wrData;
        end
        next_rdData = mem[rdAddr];
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            for (int i = 0; i < DEPTH; i++) begin
                mem[i] <= '0;
            end
            rdData <= '0;
        end else begin
            mem <= next_mem;
            rdData <= next_rdData;
        end
    end
endmodule : xio_level_mem
`default_nettype wire

// *** verif/xio_line_partner.sv ***
// external equipment model on the auxiliary digital lines
`timescale 1ns/1ps
`default_nettype none
module xio_line_partner #(
    parameter int WIDTH = 24
) (
    // lines seen from the device
    input wire logic [WIDTH-1:0] lineOut,
    input wire logic [WIDTH-1:0] lineOe,
    output logic [WIDTH-1:0] lineIn,
    // pattern the equipment drives
    input wire logic [WIDTH-1:0] extDrive
);
    // equipment drives only pins the device has released, never fights
    always_comb begin
        for (int i = 0; i < WIDTH; i++) begin
            lineIn[i] = lineOe[i] ? lineOut[i] : extDrive[i];
        end
    end
endmodule : xio_line_partner
`default_nettype wire

// *** verif/xio_port_test.sv ***
// self-checking bench for the extra i/o port
`timescale 1ns/1ps
`default_nettype none
module xio_port_test;
    import xio_pkg::*;
    logic core_clk = 1'h0;
    logic rst = 1'h1;
    logic [ADDR_W-1:0] address = '0;
    logic read = 1'h0;
    logic write = 1'h0;
    logic [31:0] writedata = '0;
    logic [31:0] readdata;
    logic waitrequest;
    logic [1:0] response;
    logic [23:0] lineIn, lineOut, lineOe, mask;
    logic [23:0] extDrive = '0;
    logic [23:0] expOut = '0;
    logic [11:0] dac0, dac1, dac2, dac3;
    logic dacLoad;
    logic [47:0] lastCodes = 48'h800800800800;
    logic [47:0] readQ[$];
    logic [47:0] dacQ[$];
    logic [31:0] pat;
    logic [2:0] dir;
    int mvs[4];
    int mismatches = 0;
    int compares = 0;
    int cycles = 0;
    int seed = 440;

    always #2.5 core_clk = ~core_clk;

    xio_port #(.NUM_GROUPS(3)) dut (
        .core_clk(core_clk), .rst(rst), .address(address), .read(read),
        .write(write), .byteenable(4'hf), .writedata(writedata),
        .readdata(readdata), .waitrequest(waitrequest),
        .response(response), .lineIn(lineIn), .lineOut(lineOut),
        .lineOe(lineOe), .dacCode0(dac0), .dacCode1(dac1),
        .dacCode2(dac2), .dacCode3(dac3), .dacLoad(dacLoad)
    );

    xio_line_partner #(.WIDTH(24)) partner (
        .lineOut(lineOut), .lineOe(lineOe), .lineIn(lineIn),
        .extDrive(extDrive)
    );

    task automatic check(input string what, input logic [47:0] exp,
            input logic [47:0] got);
        compares++;
        if (got !== exp) begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    task automatic close_out;
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : close_out

    // one access; request held until waitrequest is seen low at an edge
    task automatic bus(input logic wr, input logic [15:0] idx,
            input logic [31:0] data);
        @(posedge core_clk);
        address <= {idx, 2'h0};
        read <= ~wr;
        write <= wr;
        writedata <= data;
        do @(posedge core_clk); while (waitrequest !== 1'h0);
        read <= 1'h0;
        write <= 1'h0;
    endtask : bus

    task automatic rd(input logic [15:0] idx, input logic [31:0] exp,
            input logic [1:0] resp);
        readQ.push_back({14'h0, resp, exp});
        bus(1'h0, idx, 32'h0);
    endtask : rd

    function automatic logic [11:0] code(input int mv);
        // mid scale is 0 mV, one code step per 5 mV
        return 12'h800 + 12'(mv / 5);
    endfunction : code

    // watcher: pairs each result with the oldest note; also the timeout
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 6000) begin
            mismatches++;
            close_out();
        end
        if (read === 1'h1 && waitrequest === 1'h0) begin
            if (readQ.size() == 0) check("read note", 48'h1, 48'h0);
            else check("readdata", readQ.pop_front(), {14'h0, response,
                readdata});
        end
        if (!rst && dacLoad === 1'h1) begin
            if (dacQ.size() == 0) check("dac note", 48'h1, 48'h0);
            else check("dac codes", dacQ.pop_front(),
                {dac0, dac1, dac2, dac3});
            lastCodes = {dac0, dac1, dac2, dac3};
        end else if (!rst) begin
            // codes may only move together with a load pulse
            check("dac hold", lastCodes, {dac0, dac1, dac2, dac3});
        end
    end

    initial begin
        repeat (5) @(posedge core_clk);
        rst <= 1'h0;
        @(posedge core_clk);
        check("lineOe", 48'h0, 48'(lineOe));
        bus(1'h1, 16'h0005, 32'hffffffff);
        rd(16'h0005, 32'h0, 2'h3);
        rd(IDX_DIRECTION, 32'h0, 2'h0);
        rd(IDX_UPDATE, 32'h0, 2'h0);
        $display("test reset done");
        for (int d = 0; d < 8; d++) begin
            dir = d[2:0];
            pat = $random(seed);
            extDrive <= pat[23:0];
            pat = $random(seed);
            mask = {{8{dir[2]}}, {8{dir[1]}}, {8{dir[0]}}};
            bus(1'h1, IDX_DIRECTION, {29'h0, dir});
            rd(IDX_DIRECTION, {29'h0, dir}, 2'h0);
            bus(1'h1, IDX_PIN_DATA, pat);
            for (int g = 0; g < 3; g++) begin
                if (dir[g]) expOut[8*g +: 8] = pat[8*g +: 8];
            end
            repeat (4) @(posedge core_clk);
            check("lineOe", 48'(mask), 48'(lineOe));
            check("lineOut", 48'(expOut), 48'(lineOut));
            rd(IDX_PIN_DATA, {8'h0, (expOut & mask) | (extDrive & ~mask)},
                2'h0);
        end
        $display("test digital done");
        mvs = '{-2000, 0, 3500, 10000};
        for (int r = 0; r < 3; r++) begin
            for (int k = 0; k < 4; k++) begin
                if (r == 1) mvs[k] = $random(seed) % 10001;
                if (r == 2) mvs[k] = k[0] ? 10000 : -10000;
                bus(1'h1, IDX_LEVEL_ZERO + 16'(k), 32'(mvs[k]));
            end
            for (int k = 0; k < 4; k++) begin
                rd(IDX_LEVEL_ZERO + 16'(k), 32'(mvs[k]), 2'h0);
            end
            bus(1'h1, IDX_UPDATE, 32'h2);
            dacQ.push_back({code(mvs[0]), code(mvs[1]), code(mvs[2]),
                code(mvs[3])});
            bus(1'h1, IDX_UPDATE, 32'h1);
            repeat (3) @(posedge core_clk);
        end
        check("dac notes left", 48'h0, 48'(dacQ.size()));
        check("read notes left", 48'h0, 48'(readQ.size()));
        $display("test analog done");
        close_out();
    end
endmodule : xio_port_test
`default_nettype wire
